// File: logic/slew_pulse_gate.sv
// slew gate with its one-shot and an axi4-lite control slave
`timescale 1ns/100ps
module slew_pulse_gate (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timing pins from outside the clock domain
   input wire logic master_trigger_pulse,
   input wire logic slew_direction_selector,
   // gate outputs
   output logic counter_out,
   output logic os_primary,
   output logic os_complement,
   output logic clk_50k,
   output logic clk_100k
);

   // *****************************************************************
   // pin synchronisers
   // *****************************************************************
   logic [2:0] mt_sync_r, mt_sync_nxt;
   logic [2:0] dir_sync_r, dir_sync_nxt;
   logic mt_level_r, mt_level_nxt;
   logic dir_level_r, dir_level_nxt;

   // level changes only once the second and third stages agree
   always_comb begin
      mt_sync_nxt = {mt_sync_r[1:0], master_trigger_pulse};
      dir_sync_nxt = {dir_sync_r[1:0], slew_direction_selector};
      mt_level_nxt = mt_level_r;
      dir_level_nxt = dir_level_r;
      if (mt_sync_r[1] == mt_sync_r[2]) begin
         mt_level_nxt = mt_sync_r[2];
      end
      if (dir_sync_r[1] == dir_sync_r[2]) begin
         dir_level_nxt = dir_sync_r[2];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mt_sync_r <= 3'h0;
         dir_sync_r <= 3'h0;
         mt_level_r <= 1'b0;
         dir_level_r <= 1'b0;
      end else begin
         mt_sync_r <= mt_sync_nxt;
         dir_sync_r <= dir_sync_nxt;
         mt_level_r <= mt_level_nxt;
         dir_level_r <= dir_level_nxt;
      end
   end

   // *****************************************************************
   // control registers and axi4-lite slave
   // *****************************************************************
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [11:0] width_r, width_nxt;
   logic aw_held_r, aw_held_nxt;
   logic w_held_r, w_held_nxt;
   logic [7:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic arready_r, arready_nxt;
   logic [15:0] shift_count_r, shift_count_nxt;
   logic [11:0] width_req;
   // one-shot state and gate output are read back through the status word
   slew_pulse_gate_pkg::os_state_e os_state_r, os_state_nxt;
   logic counter_r, counter_nxt;

   // awready/wready registered: each high while its own channel holds nothing and no response waits
   always_comb begin
      ctrl_nxt = ctrl_r;
      width_nxt = width_r;
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      width_req = width_r;
      if (s_axi_awvalid && awready_r) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (aw_held_r && w_held_r && !bvalid_r) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = slew_pulse_gate_pkg::RESP_OKAY;
         unique case (aw_addr_r)
            slew_pulse_gate_pkg::CTRL_OFS: begin
               if (w_strb_r[0]) begin
                  ctrl_nxt = w_data_r[1:0];
               end
            end
            slew_pulse_gate_pkg::WIDTH_OFS: begin
               width_req = width_r;
               if (w_strb_r[0]) begin
                  width_req[7:0] = w_data_r[7:0];
               end
               if (w_strb_r[1]) begin
                  width_req[11:8] = w_data_r[11:8];
               end
               // clamp to the settable range
               if (width_req < 12'(slew_pulse_gate_pkg::WIDTH_MIN_CYC)) begin
                  width_nxt = 12'(slew_pulse_gate_pkg::WIDTH_MIN_CYC);
               end else if (width_req > 12'(slew_pulse_gate_pkg::WIDTH_MAX_CYC)) begin
                  width_nxt = 12'(slew_pulse_gate_pkg::WIDTH_MAX_CYC);
               end else begin
                  width_nxt = width_req;
               end
            end
            slew_pulse_gate_pkg::STATUS_OFS: begin
               bresp_nxt = slew_pulse_gate_pkg::RESP_SLVERR; // read only
            end
            default: begin
               bresp_nxt = slew_pulse_gate_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && arready_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = slew_pulse_gate_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            slew_pulse_gate_pkg::CTRL_OFS: rdata_nxt = {30'h0, ctrl_r};
            slew_pulse_gate_pkg::WIDTH_OFS: rdata_nxt = {20'h0, width_r};
            slew_pulse_gate_pkg::STATUS_OFS: begin
               rdata_nxt = {shift_count_r, 12'h0, os_state_r == slew_pulse_gate_pkg::OS_FIRE,
                            dir_level_r, mt_level_r, counter_r};
            end
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = slew_pulse_gate_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt = !w_held_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= slew_pulse_gate_pkg::CTRL_RESET;
         width_r <= slew_pulse_gate_pkg::WIDTH_RESET;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         rvalid_r <= 1'b0;
         rresp_r <= 2'h0;
         rdata_r <= 32'h0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         arready_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         width_r <= width_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         arready_r <= arready_nxt;
      end
   end

   // *****************************************************************
   // phase generator, one-shot and gate
   // *****************************************************************
   localparam int PH_W = 7;
   logic [PH_W-1:0] ph_cnt_r, ph_cnt_nxt;
   logic c100_r, c100_nxt;
   logic c50_r, c50_nxt;
   logic armed_r, armed_nxt;
   logic [11:0] os_cnt_r, os_cnt_nxt;
   logic mt_prev_r, mt_prev_nxt;
   logic primary_r, primary_nxt;
   logic comp_r, comp_nxt;
   logic fire_now;
   logic gate50;
   logic gate100;
   logic search;
   logic dir_right;

   // a window aligned to the 50k period covers one 50k and two 100k pulses when at most 500 cycles long
   always_comb begin
      search = ctrl_r[slew_pulse_gate_pkg::CTRL_SEARCH_BIT];
      dir_right = dir_level_r | ctrl_r[slew_pulse_gate_pkg::CTRL_DIR_BIT];
      ph_cnt_nxt = ph_cnt_r + PH_W'(1);
      c100_nxt = c100_r;
      c50_nxt = c50_r;
      fire_now = 1'b0;
      if (ph_cnt_r == PH_W'(slew_pulse_gate_pkg::HALF_100K_CYC - 1)) begin
         ph_cnt_nxt = '0;
         c100_nxt = !c100_r;
         if (c100_r) begin
            c50_nxt = !c50_r;
            // start the window on a 50k period boundary
            fire_now = armed_r && c50_r;
         end
      end
      mt_prev_nxt = mt_level_r;
      armed_nxt = armed_r;
      os_state_nxt = os_state_r;
      os_cnt_nxt = os_cnt_r;
      // only the falling edge of the trigger arms the one-shot
      if (mt_prev_r && !mt_level_r && search && os_state_r == slew_pulse_gate_pkg::OS_IDLE) begin
         armed_nxt = 1'b1;
      end
      unique case (os_state_r)
         slew_pulse_gate_pkg::OS_IDLE: begin
            if (fire_now) begin
               armed_nxt = 1'b0;
               os_state_nxt = slew_pulse_gate_pkg::OS_FIRE;
               os_cnt_nxt = width_r;
            end
         end
         slew_pulse_gate_pkg::OS_FIRE: begin
            // single pulse then back to rest
            os_cnt_nxt = os_cnt_r - 12'h001;
            if (os_cnt_r == 12'h001) begin
               os_state_nxt = slew_pulse_gate_pkg::OS_IDLE;
            end
         end
      endcase
      // outputs are exact complements of one state
      primary_nxt = (os_state_nxt == slew_pulse_gate_pkg::OS_FIRE);
      comp_nxt = !primary_nxt;
      // 50k passes only while complement is high
      gate50 = c50_nxt & comp_nxt;
      // 100k path shut unless right slew with pulse active
      gate100 = c100_nxt & primary_nxt & dir_right;
      // inverted or of both paths; in track only the inverted 50k
      counter_nxt = !(gate50 | gate100);
   end

   // shift tally: one added as each one-shot window ends, left or right alike
   always_comb begin
      shift_count_nxt = shift_count_r;
      if (os_state_r == slew_pulse_gate_pkg::OS_FIRE && os_state_nxt == slew_pulse_gate_pkg::OS_IDLE) begin
         shift_count_nxt = shift_count_r + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ph_cnt_r <= '0;
         c100_r <= 1'b0;
         c50_r <= 1'b0;
         os_state_r <= slew_pulse_gate_pkg::OS_IDLE;
         armed_r <= 1'b0;
         os_cnt_r <= 12'h000;
         mt_prev_r <= 1'b0;
         counter_r <= 1'b1;
         primary_r <= 1'b0;
         comp_r <= 1'b1;
         shift_count_r <= 16'h0000;
      end else begin
         ph_cnt_r <= ph_cnt_nxt;
         c100_r <= c100_nxt;
         c50_r <= c50_nxt;
         os_state_r <= os_state_nxt;
         armed_r <= armed_nxt;
         os_cnt_r <= os_cnt_nxt;
         mt_prev_r <= mt_prev_nxt;
         counter_r <= counter_nxt;
         primary_r <= primary_nxt;
         comp_r <= comp_nxt;
         shift_count_r <= shift_count_nxt;
      end
   end

   // output drive, all from flip-flops
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign counter_out = counter_r;
   assign os_primary = primary_r;
   assign os_complement = comp_r;
   assign clk_50k = c50_r;
   assign clk_100k = c100_r;

endmodule : slew_pulse_gate

// File: logic/slew_pulse_gate_pkg.sv
// constants shared by the slew gate and its one-shot
// What this block does
// - in track the gate passes the 50 kHz clock inverted, nothing added or removed
// - deleting one counter pulse lengthens the master trigger interval by 20 us
// - adding one counter pulse shortens the master trigger interval by 20 us
// - the 50 kHz path opens only when the clock and one-shot complement agree
// - in track the 100 kHz path stays closed
// - counter output is the inverted OR of both gated paths
// - at full slew speed the one-shot fires once per master trigger
// - on firing, primary output goes active and complement goes idle-low
// - slew left blocks exactly one 50 kHz pulse at widths up to 30 us, 100 kHz path closed
// - closing the direction selector lets the one-shot pulse open the 100 kHz path
// - slew right blocks one 50 kHz pulse and passes two 100 kHz pulses at widths up to 25 us
// - the one-shot fires only on the falling edge of its trigger input
// - the one-shot drives two complementary outputs of equal duration
// - one-shot duration is settable from 20 to 50 us
// - one pulse per trigger edge, then idle until the next trigger
package slew_pulse_gate_pkg;

   // *****************************************************************
   // clock and timing
   // *****************************************************************
   localparam int CLK_HZ = 20000000;
   localparam int PHASE_HZ = 100000;
   // 20 MHz / 100 kHz half-period = 100 cycles per 100 kHz half-cycle
   localparam int HALF_100K_CYC = CLK_HZ / (2 * PHASE_HZ);
   localparam int WIDTH_MIN_US = 20;
   localparam int WIDTH_MAX_US = 50;
   localparam int WIDTH_CYC_PER_US = CLK_HZ / 1000000;
   localparam int WIDTH_MIN_CYC = WIDTH_MIN_US * WIDTH_CYC_PER_US;
   localparam int WIDTH_MAX_CYC = WIDTH_MAX_US * WIDTH_CYC_PER_US;
   localparam int SHIFT_US = 20;

   // *****************************************************************
   // register map
   // *****************************************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] WIDTH_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam int CTRL_SEARCH_BIT = 0;
   localparam int CTRL_DIR_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [11:0] WIDTH_RESET = 12'h190;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      OS_IDLE = 2'b01,
      OS_FIRE = 2'b10
   } os_state_e;

endpackage : slew_pulse_gate_pkg

// File: tb/pulse_rate_counter_model.sv
// far-side model: master trigger source and counter input tally
`timescale 1ns/100ps
module pulse_rate_counter_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // gate side
   input wire logic counter_out,
   output logic master_trigger_pulse,
   output int unsigned n_pulses
);
   logic last_r;
   // one counter step per falling edge of the gate output
   always @(posedge aclk) begin
      last_r <= counter_out;
      if (!aresetn) n_pulses <= 0;
      else if (last_r && !counter_out) n_pulses <= n_pulses + 1;
   end
   // idles high; only its trailing falling edge should fire the one-shot
   task automatic set_trig(input logic lvl);
      master_trigger_pulse <= lvl;
   endtask : set_trig
   initial master_trigger_pulse = 1'b1;
endmodule : pulse_rate_counter_model

// File: tb/slew_pulse_gate_checker.sv
// port-level assertions for the slew gate
`timescale 1ns/100ps
module slew_pulse_gate_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // gate pins
   input wire logic slew_direction_selector,
   input wire logic counter_out,
   input wire logic os_primary,
   input wire logic os_complement,
   input wire logic clk_50k,
   input wire logic clk_100k
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   int unsigned os_len_r;
   int unsigned os_len_nxt;
   // **************************************************
   // window length tally
   // **************************************************
   always_comb begin
      os_len_nxt = os_primary ? os_len_r + 1 : 0;
   end
   // counting avoids a long repetition the tools would unroll
   always_ff @(posedge aclk) begin
      os_len_r <= aresetn ? os_len_nxt : 0;
   end
   // settled window with a direction pin held past its synchroniser
   sequence s_win(bit d);
      os_primary && $past(os_primary) && slew_direction_selector == d
         && $past(slew_direction_selector, 6) == d;
   endsequence
   property p_compl;
      os_complement != os_primary;
   endproperty
   a_compl: assert property (p_compl) else $error("one-shot outputs agree");
   property p_track;
      !os_primary && !$past(os_primary) |-> counter_out == !clk_50k;
   endproperty
   a_track: assert property (p_track) else $error("track output wrong");
   property p_left;
      s_win(1'b0) |-> counter_out;
   endproperty
   a_left: assert property (p_left) else $error("slew left let a pulse by");
   property p_right;
      s_win(1'b1) |-> counter_out == !clk_100k;
   endproperty
   a_right: assert property (p_right) else $error("slew right output wrong");
   property p_half100;
      $rose(clk_100k) |-> ##100 $fell(clk_100k);
   endproperty
   a_half100: assert property (p_half100) else $error("fast phase half period");
   property p_half50;
      $rose(clk_50k) |-> ##200 $fell(clk_50k);
   endproperty
   a_half50: assert property (p_half50) else $error("slow phase half period");
   property p_align;
      $rose(os_primary) |-> $fell(clk_50k) && $fell(clk_100k);
   endproperty
   a_align: assert property (p_align) else $error("window off phase");
   property p_len;
      $fell(os_primary) |-> os_len_r >= 400 && os_len_r <= 1000;
   endproperty
   a_len: assert property (p_len) else $error("window length out of range");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule : slew_pulse_gate_checker
bind slew_pulse_gate slew_pulse_gate_checker chk_u (.aclk, .aresetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .slew_direction_selector, .counter_out, .os_primary, .os_complement, .clk_50k, .clk_100k);

// File: tb/slew_pulse_gate_test.sv
// self-checking bench for the slew gate
`timescale 1ns/100ps
module slew_pulse_gate_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic slew_direction_selector = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic master_trigger_pulse, counter_out, os_primary, os_complement, clk_50k, clk_100k;
   int unsigned n_pulses;
   int n_fail = 0;
   int tests_run = 0;
   slew_pulse_gate dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_trigger_pulse,
      .slew_direction_selector, .counter_out, .os_primary, .os_complement, .clk_50k, .clk_100k);
   pulse_rate_counter_model pm_u (.aclk, .aresetn, .counter_out, .master_trigger_pulse,
      .n_pulses);
   // 20 MHz clock
   always #25 aclk = ~aclk;
   // **************************************************
   // shared tasks
   // **************************************************
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   // a wait that used up its bound ends the run
   task automatic guard(input int i);
      if (i >= 1000) begin
         n_fail++;
         report_and_stop();
      end
   endtask : guard
   // values are read right after an edge, before that edge's updates land
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 1000 && !(s_axi_bvalid && s_axi_bready); i++) begin
         @(posedge aclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      end
      guard(i);
      check({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      s_axi_wdata <= ~d;
      @(posedge aclk);
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                           input logic [1:0] er);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 1000 && !(s_axi_rvalid && s_axi_rready); i++) begin
         @(posedge aclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      end
      guard(i);
      check(s_axi_rdata & m, e);
      check({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : axi_read
   // trigger just after a slow-phase rise, then tally pulses over 3800 cycles
   task automatic measure(input logic lvl, input int unsigned e);
      int i;
      int unsigned n0;
      for (i = 0; i < 1000 && clk_50k; i++) @(posedge aclk);
      guard(i);
      for (i = 0; i < 1000 && !clk_50k; i++) @(posedge aclk);
      guard(i);
      pm_u.set_trig(lvl);
      // the fall tallied on this very edge belongs to the previous period
      @(posedge aclk);
      n0 = n_pulses;
      repeat (3800) @(posedge aclk);
      check(n_pulses - n0, e);
   endtask : measure
   // **************************************************
   // main sequence
   // **************************************************
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axi_read(slew_pulse_gate_pkg::CTRL_OFS, 32'hFFFFFFFF, 32'h0, 2'h0);
      axi_read(slew_pulse_gate_pkg::WIDTH_OFS, 32'hFFF, 32'h190, 2'h0);
      axi_write(slew_pulse_gate_pkg::WIDTH_OFS, 32'h64, 2'h0);
      axi_read(slew_pulse_gate_pkg::WIDTH_OFS, 32'hFFF, 32'h190, 2'h0);
      axi_write(slew_pulse_gate_pkg::WIDTH_OFS, 32'h7D0, 2'h0);
      axi_read(slew_pulse_gate_pkg::WIDTH_OFS, 32'hFFF, 32'h3E8, 2'h0);
      axi_write(slew_pulse_gate_pkg::WIDTH_OFS, 32'h190, 2'h0);
      axi_write(slew_pulse_gate_pkg::STATUS_OFS, 32'hFFFF, 2'h2);
      axi_read(8'h0C, 32'hFFFFFFFF, 32'h0, 2'h2);
      // track: a trigger edge must not touch the pulse train
      measure(1'b0, 9);
      measure(1'b1, 9);
      axi_write(slew_pulse_gate_pkg::CTRL_OFS, 32'h1, 2'h0);
      measure(1'b0, 8);
      measure(1'b1, 9);
      slew_direction_selector <= 1'b1;
      measure(1'b0, 10);
      axi_read(slew_pulse_gate_pkg::STATUS_OFS, 32'hFFFF0000, 32'h20000, 2'h0);
      report_and_stop();
   end
endmodule : slew_pulse_gate_test
